// ### hbw_checker.sv
// pin-level assertions for the host bus wait/ack link
module hbw_checker #(
  parameter int unsigned BUSY_CYC = hbw_pkg::HBW_BUSY_CYC_DEF
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [1:0] BUS_TYPE_IN,
  input wire logic cs_n,
  input wire logic addr_strobe_n,
  input wire logic wait_o,
  input wire logic wait_oe,
  input wire logic test_mode_enable,
  input wire logic scan_chain_enable,
  input wire logic wait_pin
);
  logic first_r;
  logic [1:0] bt_r;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  // later bus type changes are ignored, so keep our own latched copy
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      first_r <= 1'b1;
      bt_r <= 2'h0;
    end else begin
      first_r <= 1'b0;
      if (first_r) begin
        bt_r <= BUS_TYPE_IN;
      end
    end
  end
  // ****************************************
  // assertions (repeat count of 2 matches bench BUSY_CYC)
  // ****************************************
  a_gen_busy_low: assert property ((bt_r == 2'h0 && $rose(wait_oe)) |-> !wait_o [*2])
    else $error("wait not low during transfer");
  a_gen_done_rel: assert property ((bt_r == 2'h0 && $rose(wait_oe)) |->
    ##BUSY_CYC (wait_o && wait_oe) ##1 !wait_oe) else $error("wait end or release wrong");
  a_ack_busy_high: assert property ((bt_r == 2'h1 && $rose(wait_oe)) |-> wait_o [*2])
    else $error("ack not high during transfer");
  a_ack_done_rel: assert property ((bt_r == 2'h1 && $rose(wait_oe)) |->
    ##BUSY_CYC (!wait_o && wait_oe) ##1 !wait_oe) else $error("ack end or release wrong");
  a_access_cause: assert property ($rose(wait_oe) |-> $past(cs_n) == 1'b0)
    else $error("pin driven without select");
  a_strobe_qual: assert property ((bt_r == 2'h1 && $rose(wait_oe)) |->
    $past(addr_strobe_n) == 1'b0) else $error("access without address strobe");
  a_clk_bus_quiet: assert property ((!first_r && bt_r == 2'h2) |-> !wait_oe)
    else $error("pin driven on enable-clocked bus");
  a_host_holds: assert property (($rose(cs_n) && bt_r != 2'h2) |->
    $past(wait_pin) == (bt_r == 2'h0)) else $error("host ended access early");
  a_reset_quiet: assert property (disable iff (1'b0) !RSTN_IN |->
    (!wait_oe && cs_n && addr_strobe_n)) else $error("outputs active in reset");
  a_test_low: assert property (!test_mode_enable && !scan_chain_enable)
    else $error("test or scan input high");
endmodule

// ### hbw_dev.sv
// hbw_dev.sv - device end: drives the shared wait/transfer_ack_n pin
module hbw_dev #(
  parameter int unsigned BUSY_CYC = hbw_pkg::HBW_BUSY_CYC_DEF
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [1:0] BUS_TYPE_IN,
  output logic XFER_START_OUT,
  output logic XFER_BUSY_OUT,
  hbw_if.dev PIN
);

  // ****************************************
  // parameter check
  // ****************************************
  // counter is HBW_CNT_W bits wide, so longer busy spans would wrap
  if (BUSY_CYC < 1 || BUSY_CYC > (2 ** hbw_pkg::HBW_CNT_W) - 1) begin : g_bad_busy_cyc
    $error("BUSY_CYC out of range");
  end

  typedef enum logic [1:0] {IDLE, BUSY, DONE, HOLD} hbw_dev_st_t;

  // ****************************************
  // declarations
  // ****************************************
  hbw_dev_st_t st_r;
  hbw_dev_st_t st_nxt;
  hbw_pkg::hbw_bus_t bus_r;
  logic bus_ok_r;
  logic [hbw_pkg::HBW_CNT_W-1:0] cnt_r;
  logic [hbw_pkg::HBW_CNT_W-1:0] cnt_nxt;
  logic access;
  logic active_lvl;
  logic drive_ok;
  logic wait_o_nxt;
  logic wait_oe_nxt;
  logic start_nxt;
  logic busy_nxt;

  // ****************************************
  // bus type capture
  // ****************************************
  // latch once after reset
  // a type change mid-run would alter the pin meaning under the host
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      bus_ok_r <= 1'b0;
    end else begin
      bus_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      bus_r <= hbw_pkg::hbw_bus_t'(hbw_pkg::HBW_BUS_RST);
    end else if (!bus_ok_r) begin
      bus_r <= hbw_pkg::hbw_bus_t'(BUS_TYPE_IN);
    end
  end

  // ****************************************
  // access qualification
  // ****************************************
  // strobe qualifies async-strobe access
  always_comb begin
    case (bus_r)
      hbw_pkg::HBW_BUS_ASYNC_STROBE: access = !PIN.cs_n && !PIN.addr_strobe_n;
      default: access = !PIN.cs_n;
    endcase
  end

  // wait is active low, ack busy level is high
  always_comb begin
    case (bus_r)
      hbw_pkg::HBW_BUS_ASYNC_STROBE: active_lvl = 1'b1;
      default: active_lvl = 1'b0;
    endcase
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      IDLE: begin
        if (bus_ok_r && access) begin
          st_nxt = BUSY;
        end
      end
      BUSY: begin
        if (cnt_r == 8'h01) begin
          st_nxt = DONE;
        end
      end
      // inactive level shows for exactly one cycle
      DONE: st_nxt = HOLD;
      // hold released until host drops the access, avoids a retrigger
      HOLD: begin
        if (!access) begin
          st_nxt = IDLE;
        end
      end
      default: st_nxt = IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_r <= IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // reloaded in idle, so each transfer gets the full busy span
  always_comb begin
    cnt_nxt = cnt_r;
    case (st_r)
      IDLE: cnt_nxt = BUSY_CYC[hbw_pkg::HBW_CNT_W-1:0];
      BUSY: cnt_nxt = cnt_r - 8'h01;
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cnt_r <= hbw_pkg::HBW_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // enable-clocked bus leaves the pin floating, never drive it
  always_comb begin
    drive_ok = (bus_r != hbw_pkg::HBW_BUS_ENABLE_CLOCKED);
  end

  always_comb begin
    wait_o_nxt = !active_lvl;
    wait_oe_nxt = 1'b0;
    case (st_nxt)
      BUSY: begin
        wait_o_nxt = active_lvl;
        wait_oe_nxt = drive_ok;
      end
      DONE: begin
        wait_o_nxt = !active_lvl;
        wait_oe_nxt = drive_ok;
      end
      default: begin
        wait_o_nxt = !active_lvl;
        wait_oe_nxt = 1'b0;
      end
    endcase
  end

  always_comb begin
    start_nxt = (st_r == IDLE) && (st_nxt == BUSY);
    busy_nxt = (st_nxt == BUSY);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PIN.wait_o <= 1'b1;
    end else begin
      PIN.wait_o <= wait_o_nxt;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PIN.wait_oe <= 1'b0;
    end else begin
      PIN.wait_oe <= wait_oe_nxt;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      XFER_START_OUT <= 1'b0;
    end else begin
      XFER_START_OUT <= start_nxt;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      XFER_BUSY_OUT <= 1'b0;
    end else begin
      XFER_BUSY_OUT <= busy_nxt;
    end
  end

endmodule

// ### hbw_host.sv
// hbw_host.sv - host end: issues accesses and waits on the shared pin
module hbw_host (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [1:0] BUS_TYPE_IN,
  input wire logic REQ_IN,
  output logic DONE_OUT,
  output logic BUSY_OUT,
  hbw_if.host PIN
);

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_END} hbw_host_st_t;

  hbw_host_st_t st_r;
  hbw_pkg::hbw_bus_t bus_r;
  logic bus_ok_r;
  logic [1:0] seen_r;
  logic done_lvl;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      bus_ok_r <= 1'b0;
      bus_r <= hbw_pkg::hbw_bus_t'(hbw_pkg::HBW_BUS_RST);
    end else begin
      bus_ok_r <= 1'b1;
      if (!bus_ok_r) begin
        bus_r <= hbw_pkg::hbw_bus_t'(BUS_TYPE_IN);
      end
    end
  end

  always_comb begin
    case (bus_r)
      hbw_pkg::HBW_BUS_ASYNC_STROBE: done_lvl = (PIN.wait_pin == 1'b0);
      default: done_lvl = (PIN.wait_pin == 1'b1);
    endcase
  end

  assign PIN.test_mode_enable = 1'b0;
  assign PIN.scan_chain_enable = 1'b0;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_r <= H_IDLE;
      seen_r <= 2'h0;
      PIN.cs_n <= 1'b1;
      PIN.addr_strobe_n <= 1'b1;
      DONE_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      DONE_OUT <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (bus_ok_r && REQ_IN) begin
            st_r <= H_WAIT;
            seen_r <= 2'h0;
            PIN.cs_n <= 1'b0;
            PIN.addr_strobe_n <= (bus_r != hbw_pkg::HBW_BUS_ASYNC_STROBE);
            BUSY_OUT <= 1'b1;
          end
        end
        H_WAIT: begin
          // ack shows its completion level one cycle only, so never skip it
          if (bus_r == hbw_pkg::HBW_BUS_ASYNC_STROBE && done_lvl) begin
            st_r <= H_END;
            PIN.cs_n <= 1'b1;
            PIN.addr_strobe_n <= 1'b1;
          // released generic pin reads high, so skip early samples
          end else if (seen_r != 2'h3) begin
            seen_r <= seen_r + 2'h1;
          end else if (bus_r == hbw_pkg::HBW_BUS_ENABLE_CLOCKED || done_lvl) begin
            st_r <= H_END;
            PIN.cs_n <= 1'b1;
            PIN.addr_strobe_n <= 1'b1;
          end
        end
        H_END: begin
          st_r <= H_IDLE;
          DONE_OUT <= 1'b1;
          BUSY_OUT <= 1'b0;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

endmodule

// ### hbw_if.sv
// hbw_if.sv - host bus pins shared between the device end and the host end
interface hbw_if;
  logic cs_n;
  logic addr_strobe_n;
  logic wait_o;
  logic wait_oe;
  logic test_mode_enable;
  logic scan_chain_enable;
  // resolved pin level; floats high through an external pull when released
  logic wait_pin;
  assign wait_pin = wait_oe ? wait_o : 1'b1;

  modport dev (
    input cs_n,
    input addr_strobe_n,
    input test_mode_enable,
    input scan_chain_enable,
    output wait_o,
    output wait_oe
  );

  modport host (
    output cs_n,
    output addr_strobe_n,
    output test_mode_enable,
    output scan_chain_enable,
    input wait_pin
  );
endinterface

// ### hbw_pkg.sv
// hbw_pkg.sv - constants and types for the host bus wait/ack pin block
package hbw_pkg;

  // ****************************************
  // bus type encoding
  // ****************************************
  typedef enum logic [1:0] {
    HBW_BUS_GENERIC,
    HBW_BUS_ASYNC_STROBE,
    HBW_BUS_ENABLE_CLOCKED
  } hbw_bus_t;

  // ****************************************
  // timing and reset constants
  // ****************************************
  localparam int unsigned HBW_CLK_MHZ = 250;
  localparam int unsigned HBW_BUSY_NS_DEF = 20;
  localparam int unsigned HBW_BUSY_CYC_DEF = (HBW_BUSY_NS_DEF * HBW_CLK_MHZ + 999) / 1000;
  localparam int unsigned HBW_CNT_W = 8;
  localparam logic [HBW_CNT_W-1:0] HBW_CNT_RST = 8'h00;
  localparam logic [1:0] HBW_BUS_RST = 2'h0;

endpackage

// ### tb_host_bus_wait_and_reset_pins.sv
// testbench joining the device end and host end of the wait/ack link
module tb_host_bus_wait_and_reset_pins;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b1;
  logic [1:0] bus_type = 2'h0;
  logic req = 1'b0;
  logic done, busy, x_start, x_busy;
  int errors = 0;
  int n_tests = 0;
  hbw_if pin_if ();
  hbw_dev #(.BUSY_CYC(2)) hbw_dev_i (.CLK_IN(clk), .RSTN_IN(rstn), .BUS_TYPE_IN(bus_type),
    .XFER_START_OUT(x_start), .XFER_BUSY_OUT(x_busy), .PIN(pin_if));
  hbw_host hbw_host_i (.CLK_IN(clk), .RSTN_IN(rstn), .BUS_TYPE_IN(bus_type), .REQ_IN(req),
    .DONE_OUT(done), .BUSY_OUT(busy), .PIN(pin_if));
  hbw_checker #(.BUSY_CYC(2)) hbw_checker_i (.CLK_IN(clk), .RSTN_IN(rstn),
    .BUS_TYPE_IN(bus_type), .cs_n(pin_if.cs_n), .addr_strobe_n(pin_if.addr_strobe_n),
    .wait_o(pin_if.wait_o), .wait_oe(pin_if.wait_oe), .wait_pin(pin_if.wait_pin),
    .test_mode_enable(pin_if.test_mode_enable), .scan_chain_enable(pin_if.scan_chain_enable));
  always #2 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] bt);
    @(negedge clk);
    rstn = 1'b0;
    bus_type = bt;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // two back-to-back accesses; bt_late tries to change the type after latching
  task automatic xfer(input logic [1:0] bt, input logic [1:0] bt_late);
    int n_oe = 0;
    int n_busy = 0;
    int n_done = 0;
    int n_st = 0;
    int n_xb = 0;
    int n_hb = 0;
    logic as_lo = 1'b0;
    do_reset(bt);
    bus_type = bt_late;
    req = 1'b1;
    for (int c = 0; c < 64 && n_done < 2; c++) begin
      @(negedge clk);
      n_oe += (pin_if.wait_oe === 1'b1);
      n_busy += (pin_if.wait_oe === 1'b1 && pin_if.wait_o === (bt == 2'h1));
      n_done += (done === 1'b1);
      as_lo |= (pin_if.addr_strobe_n === 1'b0);
      n_st += (x_start === 1'b1);
      n_xb += (x_busy === 1'b1);
      n_hb += (busy === 1'b1);
    end
    req = 1'b0;
    repeat (4) @(negedge clk);
    n_oe += 0;
    chk(8'(n_oe), (bt == 2'h2) ? 8'h00 : 8'h06);
    chk(8'(n_busy), (bt == 2'h2) ? 8'h00 : 8'h04);
    chk({7'h00, as_lo}, {7'h00, bt == 2'h1});
    chk(8'(n_done), 8'h02);
    chk(8'(n_st), 8'h02);
    chk(8'(n_xb), 8'h04);
    chk(8'(n_hb), 8'h0A);
  endtask
  // reset arrives in the middle of a busy transfer
  task automatic mid_reset();
    do_reset(2'h1);
    req = 1'b1;
    repeat (3) @(negedge clk);
    chk({6'h00, x_busy, pin_if.wait_oe}, 8'h03);
    rstn = 1'b0;
    req = 1'b0;
    #1;
    chk({busy, x_busy, x_start, done, pin_if.wait_oe, pin_if.cs_n, pin_if.addr_strobe_n},
      8'h03);
    @(negedge clk);
    rstn = 1'b1;
  endtask
  initial begin
    #1 rstn = 1'b0;
    xfer(2'h0, 2'h0);
    xfer(2'h1, 2'h1);
    xfer(2'h2, 2'h2);
    xfer(2'h1, 2'h0);
    mid_reset();
    end_of_test();
  end
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule
